/* uhf_asserts.sv */
// Port-level checks for the frame control block
`timescale 1ns/1ns
module uhf_asserts import uhf_pkg::*; #(
	parameter int FRAME_CYC = UHF_FRAME_CYC
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic dma_req,
	input wire logic [31:0] dma_addr,
	input wire logic [31:0] dma_data,
	input wire logic dma_ack,
	input wire logic port_power,
	input wire logic [3:0] list_en,
	input wire logic [1:0] func_state
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	wire wr_acc = psel && penable && pwrite && pready;
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_fnum_done;
		dma_req && dma_ack && dma_addr[7:0] == UHF_CA_FNUM;
	endsequence
	a_apb_answer: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_dma_hold: assert property (dma_req && !dma_ack |=>
		dma_req && $stable(dma_addr) && $stable(dma_data))
		else $error("dma request dropped or changed");
	a_fnum_first: assert property ($rose(dma_req) |-> dma_addr[7:0] == UHF_CA_FNUM)
		else $error("first write not frame number");
	a_pad_zero: assert property (dma_req && dma_addr[7:0] == UHF_CA_FNUM |->
		dma_data[31:16] == 16'h0)
		else $error("pad word not zero");
	a_area_words: assert property (dma_req |-> dma_addr[7:0] inside {8'h80, 8'h84})
		else $error("write outside frame and head words");
	a_done_next: assert property (s_fnum_done |=> !dma_req || dma_addr[7:0] == UHF_CA_DONE)
		else $error("head write out of order");
	a_list_map: assert property (wr_acc && paddr == UHF_OFF_CONTROL |-> ##2
		list_en == $past(pwdata[5:2], 2) && func_state == $past(pwdata[7:6], 2))
		else $error("control fields wrong");
	a_power_on: assert property (wr_acc && paddr == UHF_OFF_RHSTAT && pwdata[16] &&
		!pwdata[0] |-> ##2 port_power)
		else $error("port power not on");
endmodule // uhf_asserts
bind uhf_top uhf_asserts #(.FRAME_CYC(FRAME_CYC)) u_chk (.clock(clock), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .dma_req(dma_req), .dma_addr(dma_addr), .dma_data(dma_data),
	.dma_ack(dma_ack), .port_power(port_power), .list_en(list_en), .func_state(func_state));

/* uhf_frame_timer.sv */
// Frame tick divider producing a one-cycle pulse each frame
`timescale 1ns/1ns
module uhf_frame_timer import uhf_pkg::*; #(
	parameter int FRAME_CYC = UHF_FRAME_CYC
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic run,
	output logic tick
);
	if (FRAME_CYC < 2) begin : g_bad_cyc
		$error("FRAME_CYC too small");
	end
	logic [31:0] cnt_r;
	wire last = (cnt_r == 32'(FRAME_CYC - 1));
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 32'h0;
			tick <= 1'b0;
		end else begin
			cnt_r <= (!run || last) ? 32'h0 : cnt_r + 32'h1;
			tick <= run && last;
		end
	end
endmodule // uhf_frame_timer

/* uhf_mem_model.sv */
// System memory answering the block's DMA writes
`timescale 1ns/1ns
module uhf_mem_model (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [3:0] lat,
	input wire logic dma_req,
	input wire logic [31:0] dma_addr,
	input wire logic [31:0] dma_data,
	output logic dma_ack
);
	logic [31:0] mem [64];
	logic [3:0] cnt_r;
	int n_done;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dma_ack <= 1'b0;
			cnt_r <= 4'h0;
			n_done <= 0;
		end else if (dma_ack) begin
			// Only the low byte indexes: the area is one aligned 256-byte block
			mem[dma_addr[7:2]] <= dma_data;
			n_done <= n_done + int'(dma_addr[7:0] == 8'h84);
			dma_ack <= 1'b0;
			cnt_r <= 4'h0;
		end else if (dma_req && cnt_r == lat) begin
			dma_ack <= 1'b1;
		end else if (dma_req) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule // uhf_mem_model

/* uhf_pkg.sv */
// Package for the frame-level control and communication-area block
package uhf_pkg;
	localparam logic [11:0] UHF_OFF_CONTROL = 12'h004;
	localparam logic [11:0] UHF_OFF_CMDSTAT = 12'h008;
	localparam logic [11:0] UHF_OFF_ISTAT = 12'h00c;
	localparam logic [11:0] UHF_OFF_IEN = 12'h010;
	localparam logic [11:0] UHF_OFF_IDIS = 12'h014;
	localparam logic [11:0] UHF_OFF_CABASE = 12'h018;
	localparam logic [11:0] UHF_OFF_CTLHEAD = 12'h020;
	localparam logic [11:0] UHF_OFF_BLKHEAD = 12'h028;
	localparam logic [11:0] UHF_OFF_DONEH = 12'h030;
	localparam logic [11:0] UHF_OFF_FMINTV = 12'h034;
	localparam logic [11:0] UHF_OFF_FNUM = 12'h03c;
	localparam logic [11:0] UHF_OFF_PERST = 12'h040;
	localparam logic [11:0] UHF_OFF_LSTH = 12'h044;
	localparam logic [11:0] UHF_OFF_RHSTAT = 12'h050;
	localparam logic [11:0] UHF_OFF_DEFER = 12'h060;
	// Communication area byte offsets
	localparam logic [7:0] UHF_CA_FNUM = 8'h80;
	localparam logic [7:0] UHF_CA_DONE = 8'h84;
	localparam logic [7:0] UHF_CA_RSVD = 8'h88;
	localparam int UHF_CA_TABLE_WORDS = 32;
	// Field positions
	localparam int UHF_CMD_RESET_BIT = 0;
	localparam int UHF_CTL_PLE = 2;
	localparam int UHF_CTL_ILE = 3;
	localparam int UHF_CTL_CLE = 4;
	localparam int UHF_CTL_BLE = 5;
	localparam int UHF_CTL_FS_LO = 6;
	localparam int UHF_IRQ_MASTER = 31;
	localparam int UHF_RH_POWER_BIT = 16;
	localparam int UHF_IRQ_SRC_NUM = 24;
	// Status bits
	localparam int UHF_ST_SO = 0;
	localparam int UHF_ST_WD = 1;
	localparam int UHF_ST_SF = 2;
	localparam int UHF_ST_RD = 3;
	localparam int UHF_ST_UE = 4;
	localparam int UHF_ST_FNO = 5;
	// Reset values and function-state codes
	localparam logic [13:0] UHF_FMINTV_RST = 14'h2edf;
	localparam logic [13:0] UHF_PERST_RST = 14'h0000;
	localparam logic [11:0] UHF_LSTH_RST = 12'h628;
	localparam logic [1:0] UHF_FS_RESET = 2'h0;
	localparam logic [1:0] UHF_FS_RESUME = 2'h1;
	localparam logic [1:0] UHF_FS_OPER = 2'h2;
	localparam logic [1:0] UHF_FS_SUSPEND = 2'h3;
	// Timing
	localparam int UHF_CLK_MHZ = 100;
	localparam int UHF_FRAME_US = 1000;
	localparam int UHF_FRAME_CYC = UHF_FRAME_US * UHF_CLK_MHZ;
	localparam int UHF_SRST_CYC = 16;
	typedef enum logic [3:0] {
		UHF_W_IDLE = 4'b0001,
		UHF_W_FNUM = 4'b0010,
		UHF_W_DONE = 4'b0100,
		UHF_W_WAIT = 4'b1000
	} uhf_wstate_t;
endpackage

/* uhf_top.sv */
// Frame control, register file and communication-area write-back
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module uhf_top import uhf_pkg::*; #(
	parameter int FRAME_CYC = UHF_FRAME_CYC
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic resume_pin,
	input wire logic sys_err,
	input wire logic overrun_evt,
	input wire logic td_retire,
	input wire logic [31:0] td_addr,
	output logic dma_req,
	output logic [31:0] dma_addr,
	output logic [31:0] dma_data,
	input wire logic dma_ack,
	output logic td_link_we,
	output logic [31:0] td_link_addr,
	output logic [31:0] td_link_data,
	output logic port_power,
	output logic [3:0] list_en,
	output logic [1:0] func_state,
	output logic irq
);
	// Resume comes from the bus side: two stages, then one more for the edge
	logic res_s1_r, res_s2_r, res_s3_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			res_s1_r <= 1'b0;
			res_s2_r <= 1'b0;
			res_s3_r <= 1'b0;
		end else begin
			res_s1_r <= resume_pin;
			res_s2_r <= res_s1_r;
			res_s3_r <= res_s2_r;
		end
	end
	wire resume_rise = res_s2_r && !res_s3_r;

	logic [31:0] control_r, istat_r, ien_r, cabase_r, ctlhead_r, blkhead_r;
	logic [31:0] retired_head_r;
	logic [13:0] fmintv_r, perst_r;
	logic [11:0] lsth_r;
	logic [15:0] fnum_r;
	logic [2:0] defer_r;
	logic srst_r;
	logic [4:0] srst_cnt_r;
	logic pwr_r;
	uhf_wstate_t ws_r;
	logic want_done_r;

	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire a_ctl = (paddr == UHF_OFF_CONTROL);
	wire a_cmd = (paddr == UHF_OFF_CMDSTAT);
	wire a_ist = (paddr == UHF_OFF_ISTAT);
	wire a_ien = (paddr == UHF_OFF_IEN);
	wire a_idis = (paddr == UHF_OFF_IDIS);
	wire a_cab = (paddr == UHF_OFF_CABASE);
	wire a_ch = (paddr == UHF_OFF_CTLHEAD);
	wire a_bh = (paddr == UHF_OFF_BLKHEAD);
	wire a_dh = (paddr == UHF_OFF_DONEH);
	wire a_fi = (paddr == UHF_OFF_FMINTV);
	wire a_fn = (paddr == UHF_OFF_FNUM);
	wire a_ps = (paddr == UHF_OFF_PERST);
	wire a_ls = (paddr == UHF_OFF_LSTH);
	wire a_rh = (paddr == UHF_OFF_RHSTAT);
	wire a_df = (paddr == UHF_OFF_DEFER);
	wire mapped = a_ctl | a_cmd | a_ist | a_ien | a_idis | a_cab | a_ch | a_bh | a_dh
		| a_fi | a_fn | a_ps | a_ls | a_rh | a_df;

	wire [1:0] fs = control_r[UHF_CTL_FS_LO+1:UHF_CTL_FS_LO];
	wire oper = (fs == UHF_FS_OPER) && !srst_r;
	logic frame_tick;
	uhf_frame_timer #(.FRAME_CYC(FRAME_CYC)) u_timer (
		.clock(clock),
		.rstn(rstn),
		.run(oper),
		.tick(frame_tick)
	);

	// Both write-backs need several memory cycles inside one frame
	if (FRAME_CYC < 16) begin : g_short_frame
		$error("FRAME_CYC too short for write-back");
	end
	// Frame-number word must sit right behind the periodic list table
	if (UHF_CA_TABLE_WORDS * 4 != int'(UHF_CA_FNUM)) begin : g_table_size
		$error("periodic table size mismatch");
	end

	wire [15:0] fnum_nxt = fnum_r + 16'h1;
	wire fno_evt = frame_tick && (fnum_nxt[15] != fnum_r[15]);

	// Overflow status lands one cycle after the counter has moved
	logic fno_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fno_r <= 1'b0;
		end else begin
			fno_r <= fno_evt;
		end
	end

	// Events from the frame engine
	logic [5:0] ev;
	logic wd_set;
	always_comb begin
		ev = 6'h0;
		// A write-back still busy at the next tick is an overrun as well
		ev[UHF_ST_SO] = (overrun_evt || (frame_tick && ws_r != UHF_W_IDLE)) && oper;
		ev[UHF_ST_WD] = wd_set;
		ev[UHF_ST_SF] = frame_tick;
		ev[UHF_ST_RD] = resume_rise;
		ev[UHF_ST_UE] = sys_err;
		ev[UHF_ST_FNO] = fno_r;
	end
	wire [5:0] clr = (wr && a_ist) ? pwdata[5:0] : 6'h0;
	wire [5:0] others = istat_r[5:0] & ien_r[5:0] & ~(6'h1 << UHF_ST_WD);
	wire ca_ok = (cabase_r[7:0] == 8'h00);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			istat_r <= 32'h0;
		end else begin
			istat_r[5:0] <= (istat_r[5:0] & ~clr) | ev;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ien_r <= 32'h0;
		end else if (wr && a_ien) begin
			ien_r <= ien_r | pwdata;
		end else if (wr && a_idis) begin
			ien_r <= ien_r & ~pwdata;
		end
	end

	// A software write wins over the resume move in the same cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			control_r <= 32'h0;
		end else if (srst_r) begin
			control_r <= 32'h0;
		end else if (wr && a_ctl) begin
			control_r <= {24'h0, pwdata[7:0]};
		end else if (resume_rise && fs == UHF_FS_SUSPEND) begin
			control_r[UHF_CTL_FS_LO+1:UHF_CTL_FS_LO] <= UHF_FS_RESUME;
		end
	end

	// Soft reset runs a fixed count; software polls the bit meanwhile
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			srst_r <= 1'b0;
			srst_cnt_r <= 5'h0;
		end else if (wr && a_cmd && pwdata[UHF_CMD_RESET_BIT]) begin
			srst_r <= 1'b1;
			srst_cnt_r <= 5'(UHF_SRST_CYC);
		end else if (srst_r) begin
			srst_cnt_r <= srst_cnt_r - 5'h1;
			if (srst_cnt_r == 5'h1) srst_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cabase_r <= 32'h0;
			ctlhead_r <= 32'h0;
			blkhead_r <= 32'h0;
		end else if (wr) begin
			if (a_cab) cabase_r <= {pwdata[31:8], 8'h00};
			if (a_ch) ctlhead_r <= pwdata;
			if (a_bh) blkhead_r <= pwdata;
		end
	end

	// Timing words are kept for software; the frame length is FRAME_CYC
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fmintv_r <= UHF_FMINTV_RST;
			perst_r <= UHF_PERST_RST;
			lsth_r <= UHF_LSTH_RST;
		end else if (wr) begin
			if (a_fi) fmintv_r <= pwdata[13:0];
			if (a_ps) perst_r <= pwdata[13:0];
			if (a_ls) lsth_r <= pwdata[11:0];
		end
	end

	// Global switching: one bit powers every port; power-off wins a tie
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pwr_r <= 1'b0;
		end else if (wr && a_rh && pwdata[0]) begin
			pwr_r <= 1'b0;
		end else if (wr && a_rh && pwdata[UHF_RH_POWER_BIT]) begin
			pwr_r <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fnum_r <= 16'h0;
		end else if (srst_r) begin
			fnum_r <= 16'h0;
		end else if (frame_tick) begin
			fnum_r <= fnum_nxt;
		end
	end

	// Deferred count: software loads it; counts down each frame
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			defer_r <= 3'h0;
		end else if (wr && a_df) begin
			defer_r <= pwdata[2:0];
		end else if (frame_tick && defer_r != 3'h0) begin
			defer_r <= defer_r - 3'h1;
		end
	end

	// Done queue is a stack: newest descriptor links to old head
	// Head handed to memory here; later retirements start a fresh chain
	wire head_taken = (ws_r == UHF_W_FNUM) && dma_ack && want_done_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			retired_head_r <= 32'h0;
			td_link_we <= 1'b0;
			td_link_addr <= 32'h0;
			td_link_data <= 32'h0;
		end else begin
			td_link_we <= td_retire;
			if (td_retire) begin
				td_link_addr <= td_addr;
				td_link_data <= head_taken ? 32'h0 : retired_head_r;
				retired_head_r <= td_addr;
			end else if (head_taken) begin
				retired_head_r <= 32'h0;
			end
		end
	end

	// Communication-area write-back; periodic table at 0..0x7f is read elsewhere
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ws_r <= UHF_W_IDLE;
			dma_req <= 1'b0;
			dma_addr <= 32'h0;
			dma_data <= 32'h0;
			wd_set <= 1'b0;
			want_done_r <= 1'b0;
		end else begin
			wd_set <= 1'b0;
			case (ws_r)
				UHF_W_IDLE: begin
					if (frame_tick && ca_ok) begin
						want_done_r <= (defer_r == 3'h0) && !istat_r[UHF_ST_WD]
							&& (retired_head_r != 32'h0);
						dma_req <= 1'b1;
						dma_addr <= {cabase_r[31:8], UHF_CA_FNUM};
						dma_data <= {16'h0, fnum_nxt};
						ws_r <= UHF_W_FNUM;
					end
				end
				UHF_W_FNUM: begin
					if (dma_ack) begin
						if (want_done_r) begin
							dma_addr <= {cabase_r[31:8], UHF_CA_DONE};
							dma_data <= {retired_head_r[31:1], |others};
							ws_r <= UHF_W_DONE;
						end else begin
							dma_req <= 1'b0;
							ws_r <= UHF_W_IDLE;
						end
					end
				end
				UHF_W_DONE: begin
					if (dma_ack) begin
						dma_req <= 1'b0;
						wd_set <= 1'b1;
						ws_r <= UHF_W_WAIT;
					end
				end
				UHF_W_WAIT: begin
					ws_r <= UHF_W_IDLE;
				end
				default: ws_r <= UHF_W_IDLE;
			endcase
		end
	end

	// Read mux; unmapped offsets read as zero
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0;
		if (a_ctl) rd = control_r;
		else if (a_cmd) rd = {31'h0, srst_r};
		else if (a_ist) rd = istat_r;
		else if (a_ien || a_idis) rd = ien_r;
		else if (a_cab) rd = cabase_r;
		else if (a_ch) rd = ctlhead_r;
		else if (a_bh) rd = blkhead_r;
		else if (a_dh) rd = retired_head_r;
		else if (a_fi) rd = {18'h0, fmintv_r};
		else if (a_fn) rd = {16'h0, fnum_r};
		else if (a_ps) rd = {18'h0, perst_r};
		else if (a_ls) rd = {20'h0, lsth_r};
		else if (a_rh) rd = {15'h0, pwr_r, 16'h0};
		else if (a_df) rd = {29'h0, defer_r};
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? rd : 32'h0;
		end
	end

	// Master enable gates the combined line as a whole
	wire irq_nxt = ien_r[UHF_IRQ_MASTER] && |(istat_r[5:0] & ien_r[5:0]);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
			port_power <= 1'b0;
			list_en <= 4'h0;
			func_state <= UHF_FS_RESET;
		end else begin
			irq <= irq_nxt;
			port_power <= pwr_r;
			list_en <= control_r[UHF_CTL_BLE:UHF_CTL_PLE];
			func_state <= fs;
		end
	end
endmodule // uhf_top

/* uhf_top_tb.sv */
// Self-checking bench for the frame control block
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module uhf_top_tb import uhf_pkg::*;;
	localparam int FC = 50;
	logic clock, rstn, psel, penable, pwrite, resume_pin, sys_err, overrun_evt, td_retire;
	logic pready, pslverr, dma_req, dma_ack, td_link_we, port_power, irq, sl;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, td_addr, dma_addr, dma_data, td_link_addr, td_link_data, rd, f0;
	logic [3:0] list_en, lat;
	logic [1:0] func_state;
	int error_cnt, n_checks, k, nd;
	uhf_top #(.FRAME_CYC(FC)) dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .resume_pin(resume_pin), .sys_err(sys_err),
		.overrun_evt(overrun_evt), .td_retire(td_retire), .td_addr(td_addr),
		.dma_req(dma_req), .dma_addr(dma_addr), .dma_data(dma_data), .dma_ack(dma_ack),
		.td_link_we(td_link_we), .td_link_addr(td_link_addr), .td_link_data(td_link_data),
		.port_power(port_power), .list_en(list_en), .func_state(func_state), .irq(irq));
	uhf_mem_model mdl (.clock(clock), .rstn(rstn), .lat(lat), .dma_req(dma_req),
		.dma_addr(dma_addr), .dma_data(dma_data), .dma_ack(dma_ack));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		final_report;
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Pin outputs copy their register one edge later; let both settle
		repeat (2) @(posedge clock);
	endtask
	task automatic retire(input logic [31:0] a, input logic [31:0] old);
		td_retire <= 1'b1;
		td_addr <= a;
		@(posedge clock);
		td_retire <= 1'b0;
		for (k = 0; td_link_we !== 1'b1 && k < 5; k++) @(posedge clock);
		`CHK("link data", old, td_link_data)
		`CHK("link addr", {1'b1, a}, {td_link_we, td_link_addr})
	endtask
	task automatic wait_done;
		for (k = 0; mdl.n_done == nd && k < 4 * FC; k++) @(posedge clock);
		`CHK("head written", 1'b1, mdl.n_done != nd)
		nd = mdl.n_done;
	endtask
	task automatic t_regs;
		apb(0, UHF_OFF_LSTH, 0);
		`CHK("lsth", 32'h628, rd)
		apb(1, UHF_OFF_PERST, 32'h2a2f);
		apb(0, UHF_OFF_PERST, 0);
		`CHK("perst", 32'h2a2f, rd)
		apb(0, 12'h0fc, 32'h5);
		`CHK("unmapped", {1'b1, 32'h0}, {sl, rd})
		for (int i = 0; i < 4; i++) begin
			apb(1, UHF_OFF_CONTROL, 32'h4 << i);
			`CHK("list_en", 4'h1 << i, list_en)
		end
		apb(1, UHF_OFF_RHSTAT, 32'h1_0000);
		`CHK("port_power", 1'b1, port_power)
	endtask
	task automatic t_srst;
		apb(1, UHF_OFF_CONTROL, 32'hbc);
		apb(1, UHF_OFF_CMDSTAT, 32'h1);
		apb(0, UHF_OFF_CMDSTAT, 0);
		`CHK("reset busy", 1'b1, rd[0])
		for (nd = 0; rd[0] !== 1'b0 && nd < 10; nd++) apb(0, UHF_OFF_CMDSTAT, 0);
		`CHK("reset end", 7'h0, {rd[0], func_state, list_en})
		nd = 0;
	endtask
	task automatic t_frame;
		lat <= 4'h2;
		apb(1, UHF_OFF_CABASE, 32'h0001_2300);
		apb(1, UHF_OFF_IEN, 32'h8000_0006);
		apb(1, UHF_OFF_CONTROL, 32'hbc);
		`CHK("func_state", 2'h2, func_state)
		retire(32'h4a00, 32'h0);
		retire(32'h4b00, 32'h4a00);
		wait_done;
		`CHK("head word", 32'h4b01, mdl.mem[33])
		`CHK("pad word", 16'h0, mdl.mem[32][31:16])
		`CHK("irq", 1'b1, irq)
		overrun_evt <= 1'b1;
		@(posedge clock);
		overrun_evt <= 1'b0;
		apb(0, UHF_OFF_ISTAT, 0);
		`CHK("status", 3'h7, rd[2:0])
		retire(32'h4c00, 32'h0);
		repeat (3 * FC) @(posedge clock);
		`CHK("no rewrite", nd, mdl.n_done)
		apb(1, UHF_OFF_IDIS, 32'h4);
		apb(1, UHF_OFF_ISTAT, 32'h3f);
		wait_done;
		`CHK("head word", 32'h4c00, mdl.mem[33])
		apb(0, UHF_OFF_FNUM, 0);
		f0 = rd;
		repeat (FC - 4) @(posedge clock);
		apb(0, UHF_OFF_FNUM, 0);
		`CHK("frame count", f0[15:0] + 16'h1, rd[15:0])
		apb(1, UHF_OFF_IDIS, 32'h8000_0000);
		`CHK("irq off", 1'b0, irq)
	endtask
	task automatic t_events;
		apb(1, UHF_OFF_CONTROL, 32'hc0);
		resume_pin <= 1'b1;
		repeat (4) @(posedge clock);
		resume_pin <= 1'b0;
		sys_err <= 1'b1;
		repeat (4) @(posedge clock);
		sys_err <= 1'b0;
		`CHK("resuming", 2'h1, func_state)
		apb(0, UHF_OFF_ISTAT, 0);
		`CHK("status", 2'h3, rd[4:3])
	endtask
	initial begin
		{psel, penable, pwrite, resume_pin, sys_err, overrun_evt, td_retire} = '0;
		paddr = '0;
		pwdata = '0;
		td_addr = '0;
		lat = 4'h0;
		rstn = 1'b0;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		t_regs;
		t_srst;
		t_frame;
		t_events;
		final_report;
	end
endmodule // uhf_top_tb
